// *** design/alu_flag_unit.sv ***
// module: combinational result and flag generation for one instruction
module alu_flag_unit (
   alu_flags_if.unit af
);
   import status_flags_pkg::*;

   // ---------------------------------------------------------------
   // adder shared by add and subtract
   // ---------------------------------------------------------------
   function automatic logic [8:0] add9(input logic [7:0] a, input logic [7:0] b, input logic cin);
      return {1'b0, a} + {1'b0, b} + {8'h00, cin};
   endfunction

   function automatic logic [4:0] add5(input logic [3:0] a, input logic [3:0] b, input logic cin);
      return {1'b0, a} + {1'b0, b} + {4'h0, cin};
   endfunction

   logic [7:0] operand_b;
   logic       sub_cin;
   logic [8:0] sum9;
   logic [4:0] sum5;

   // subtract adds the two's complement of the working value
   always_comb begin
      operand_b = (af.op == OP_SUBTRACT_FILE) ? ~af.working : af.working;
      sub_cin   = (af.op == OP_SUBTRACT_FILE);
      sum9      = add9(af.dest_value, operand_b, sub_cin);
      sum5      = add5(af.dest_value[3:0], operand_b[3:0], sub_cin);
   end

   // result, flags and which flags the operation affects
   always_comb begin
      af.result       = af.dest_value;
      af.zero         = 1'b0;
      af.nibble_carry = 1'b0;
      af.carry        = 1'b0;
      af.zero_hit     = 1'b0;
      af.carry_hit    = 1'b0;
      case (af.op)
         OP_ADD_FILE, OP_SUBTRACT_FILE: begin
            af.result       = sum9[7:0];
            af.nibble_carry = sum5[4];
            af.carry        = sum9[8];
            af.zero_hit     = 1'b1;
            af.carry_hit    = 1'b1;
         end
         OP_ROTATE_LEFT: begin
            af.result    = {af.dest_value[6:0], af.carry_in};
            af.carry     = af.dest_value[7];
            af.carry_hit = 1'b1;
         end
         OP_ROTATE_RIGHT: begin
            af.result    = {af.carry_in, af.dest_value[7:1]};
            af.carry     = af.dest_value[0];
            af.carry_hit = 1'b1;
         end
         OP_CLEAR_FILE: begin
            af.result   = 8'h00;
            af.zero_hit = 1'b1;
         end
         OP_LOGIC: begin
            af.result   = af.dest_value & af.working;
            af.zero_hit = 1'b1;
         end
         OP_MOVE_FROM_WORKING: af.result = af.working;
         OP_NIBBLE_SWAP:       af.result = {af.dest_value[3:0], af.dest_value[7:4]};
         OP_BIT_CLEAR:         af.result = af.dest_value & ~af.working;
         OP_BIT_SET:           af.result = af.dest_value | af.working;
         default:              af.result = af.dest_value;
      endcase
      af.zero = (af.result == 8'h00);
   end

endmodule

// *** design/alu_flags_if.sv ***
// interface: alu result and flags between the main block and the flag unit
interface alu_flags_if;
   import status_flags_pkg::*;
   op_type     op;
   logic [7:0] dest_value;
   logic [7:0] working;
   logic       carry_in;
   logic [7:0] result;
   logic       zero;
   logic       nibble_carry;
   logic       carry;
   logic       zero_hit;
   logic       carry_hit;

   modport core (output op, output dest_value, output working, output carry_in,
                 input result, input zero, input nibble_carry, input carry, input zero_hit, input carry_hit);
   modport unit (input op, input dest_value, input working, input carry_in,
                 output result, output zero, output nibble_carry, output carry, output zero_hit, output carry_hit);
endinterface

// *** design/status_flags_pkg.sv ***
// package: offsets, field positions, reset values and codes of the status flag register
package status_flags_pkg;

   // ---------------------------------------------------------------
   // data-memory addresses of the mirrored register
   // ---------------------------------------------------------------
   localparam logic [8:0] STATUS_ADDR_BANK0 = 9'h003;
   localparam logic [8:0] STATUS_ADDR_BANK1 = 9'h083;
   localparam logic [8:0] STATUS_ADDR_BANK2 = 9'h103;
   localparam logic [8:0] STATUS_ADDR_BANK3 = 9'h183;
   localparam logic [6:0] STATUS_LOW_ADDR   = 7'h03;

   // ---------------------------------------------------------------
   // software register port offsets
   // ---------------------------------------------------------------
   localparam logic [3:0] REG_IRQ_STATUS = 4'h1;
   localparam logic [3:0] REG_IRQ_MASK   = 4'h2;
   localparam logic [3:0] REG_FLAGS      = 4'h3;

   // ---------------------------------------------------------------
   // field positions of the flag register
   // ---------------------------------------------------------------
   localparam int BIT_INDIRECT_BANK = 7;
   localparam int BIT_DIRECT_HI     = 6;
   localparam int BIT_DIRECT_LO     = 5;
   localparam int BIT_WATCHDOG_EXP  = 4;
   localparam int BIT_SLEEP_ENTERED = 3;
   localparam int BIT_ZERO          = 2;
   localparam int BIT_NIBBLE_CARRY  = 1;
   localparam int BIT_CARRY         = 0;

   // ---------------------------------------------------------------
   // reset values and write masks
   // ---------------------------------------------------------------
   localparam logic [7:0] FLAGS_RESET    = 8'h18;
   localparam logic [7:0] WRITABLE_MASK  = 8'hE7;
   localparam logic [7:0] ALU_FLAG_MASK  = 8'h07;
   localparam logic [2:0] IRQ_RESET      = 3'h0;

   // interrupt status bits: watchdog time-out, sleep entry, carry set
   localparam int IRQ_TIMEOUT = 0;
   localparam int IRQ_SLEEP   = 1;
   localparam int IRQ_CARRY   = 2;

   // ---------------------------------------------------------------
   // operation codes presented by the core
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_NONE,
      OP_MOVE_FROM_WORKING,
      OP_BIT_CLEAR,
      OP_BIT_SET,
      OP_NIBBLE_SWAP,
      OP_CLEAR_FILE,
      OP_ADD_FILE,
      OP_SUBTRACT_FILE,
      OP_ROTATE_LEFT,
      OP_ROTATE_RIGHT,
      OP_LOGIC
   } op_type;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // any of the four mirrored addresses
   function automatic logic is_status_addr(input logic [8:0] addr);
      return addr[6:0] == STATUS_LOW_ADDR;
   endfunction

endpackage

// *** design/status_flags_register.sv ***
// module: processor status flag register with bank selects, reset causes and alu flags
// Operation
// - Alu flags take results, not destination write
// - Reset-cause flags ignore instruction writes
// - Clear-file gives 000u u1uu
// - Bit 7 picks indirect bank pair
// - Bits 6-5 pick direct 128-byte bank
// - Expiry flag: set power-up/kick/sleep, clear timeout
// - Sleep flag: set power-up/kick, clear sleep
// - Zero flag follows result being zero
// - Nibble carry is carry from bit 3
// - Carry is carry out of bit 7
// - Subtract adds complement; carries are inverted borrow
// - Rotates load carry with shifted-out bit
// - Reset: 000, 11, low bits held
// - Register answers at 03h/83h/103h/183h
module status_flags_register (
   // clock, reset, enable
   input  wire logic                        clock,
   input  wire logic                        rst,
   input  wire logic                        clk_en,
   // instruction execution from the core
   input  wire logic                        exec_valid,
   input  wire status_flags_pkg::op_type    exec_op,
   input  wire logic [8:0]                  exec_addr,
   input  wire logic [7:0]                  exec_dest_value,
   input  wire logic [7:0]                  exec_working,
   input  wire logic                        exec_writes_file,
   // reset-cause events
   input  wire logic                        watchdog_kick_op,
   input  wire logic                        sleep_op,
   input  wire logic                        watchdog_timeout,
   // results and bank addressing
   output logic [7:0]                       exec_result,
   output logic                             status_hit,
   output logic [7:0]                       flags,
   output logic [1:0]                       direct_bank_select,
   output logic                             indirect_bank_select,
   output logic [8:0]                       direct_base,
   output logic [8:0]                       indirect_base,
   // software register port
   input  wire logic [3:0]                  sw_addr,
   input  wire logic [7:0]                  sw_wdata,
   input  wire logic                        sw_write,
   input  wire logic                        sw_read,
   output logic [7:0]                       sw_rdata,
   output logic                             irq
);
   import status_flags_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0] flags;
      logic [2:0] irq_status;
      logic [2:0] irq_mask;
      logic [7:0] rdata;
      logic [7:0] result;
   } state_type;

   state_type state_q;
   state_type state_d;

   alu_flags_if af ();

   // alu and flag generation
   alu_flag_unit alu_flag_unit_inst (
      .af (af)
   );

   logic       hit;
   logic [7:0] alu_flags;
   logic [7:0] alu_keep;
   logic [7:0] written;
   logic [7:0] write_mask;

   // drive the flag unit
   always_comb begin
      af.op         = exec_valid ? exec_op : OP_NONE;
      af.dest_value = exec_dest_value;
      af.working    = exec_working;
      af.carry_in   = state_q.flags[BIT_CARRY];
   end

   // address decode across all four banks
   assign hit = exec_valid && is_status_addr(exec_addr);

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      state_d   = state_q;
      alu_flags = state_q.flags;
      alu_keep  = 8'h00;
      written   = state_q.flags;
      if (exec_valid) begin
         state_d.result = af.result;
         // alu flag updates
         if (af.zero_hit) begin
            alu_flags[BIT_ZERO] = af.zero;
            alu_keep[BIT_ZERO]  = 1'b1;
         end
         if (af.carry_hit) begin
            alu_flags[BIT_CARRY] = af.carry;
            alu_keep[BIT_CARRY]  = 1'b1;
         end
         if (exec_op == OP_ADD_FILE || exec_op == OP_SUBTRACT_FILE) begin
            alu_flags[BIT_NIBBLE_CARRY] = af.nibble_carry;
            alu_keep[BIT_NIBBLE_CARRY]  = 1'b1;
         end
      end
      // destination write: writable bits only; any alu flag update blocks all three alu bits
      write_mask = (alu_keep != 8'h00) ? (WRITABLE_MASK & ~ALU_FLAG_MASK) : WRITABLE_MASK;
      if (hit && exec_writes_file) begin
         written = (state_q.flags & ~write_mask) | (af.result & write_mask);
      end
      state_d.flags = (written & ~alu_keep) | (alu_flags & alu_keep);
      // reset-cause events; time-out wins over a kick in the same cycle
      if (watchdog_kick_op) begin
         state_d.flags[BIT_WATCHDOG_EXP]  = 1'b1;
         state_d.flags[BIT_SLEEP_ENTERED] = 1'b1;
      end
      if (sleep_op) begin
         state_d.flags[BIT_WATCHDOG_EXP]  = 1'b1;
         state_d.flags[BIT_SLEEP_ENTERED] = 1'b0;
      end
      if (watchdog_timeout) begin
         state_d.flags[BIT_WATCHDOG_EXP] = 1'b0;
      end

      // software read port, read clears interrupt status
      state_d.rdata = 8'h00;
      if (sw_read) begin
         case (sw_addr)
            REG_IRQ_STATUS: begin
               state_d.rdata      = {5'h00, state_q.irq_status};
               state_d.irq_status = IRQ_RESET;
            end
            REG_IRQ_MASK: state_d.rdata = {5'h00, state_q.irq_mask};
            REG_FLAGS:    state_d.rdata = state_q.flags;
            default:      state_d.rdata = 8'h00;
         endcase
      end
      if (sw_write && sw_addr == REG_IRQ_MASK) begin
         state_d.irq_mask = sw_wdata[2:0];
      end
      // sticky events, set wins over the read clear
      if (watchdog_timeout) begin
         state_d.irq_status[IRQ_TIMEOUT] = 1'b1;
      end
      if (sleep_op) begin
         state_d.irq_status[IRQ_SLEEP] = 1'b1;
      end
      if (alu_keep[BIT_CARRY] && alu_flags[BIT_CARRY]) begin
         state_d.irq_status[IRQ_CARRY] = 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   // low flag bits keep their value through reset (undefined at power-on)
   always_ff @(posedge clock) begin
      if (rst) begin
         state_q.flags[7:3] <= FLAGS_RESET[7:3];
         state_q.irq_status <= IRQ_RESET;
         state_q.irq_mask   <= IRQ_RESET;
         state_q.rdata      <= 8'h00;
         state_q.result     <= 8'h00;
      end else if (clk_en) begin
         state_q <= state_d;
      end
   end

   // ---------------------------------------------------------------
   // outputs and bank address bases
   // ---------------------------------------------------------------
   assign flags                = state_q.flags;
   assign exec_result          = state_q.result;
   assign status_hit           = hit;
   assign sw_rdata             = state_q.rdata;
   assign irq                  = |(state_q.irq_status & state_q.irq_mask);
   assign indirect_bank_select = state_q.flags[BIT_INDIRECT_BANK];
   assign direct_bank_select   = state_q.flags[BIT_DIRECT_HI:BIT_DIRECT_LO];
   assign indirect_base        = {state_q.flags[BIT_INDIRECT_BANK], 8'h00};
   assign direct_base          = {state_q.flags[BIT_DIRECT_HI:BIT_DIRECT_LO], 7'h00};

endmodule

// *** tb/status_flags_asserts.sv ***
// checker: concurrent assertions on the status flag register ports
module status_flags_asserts
   import status_flags_pkg::*;
(
   // clock and reset
   input wire logic                     clock,
   input wire logic                     rst,
   input wire logic                     clk_en,
   // instruction and events
   input wire logic                     exec_valid,
   input wire status_flags_pkg::op_type exec_op,
   input wire logic [8:0]               exec_addr,
   input wire logic                     exec_writes_file,
   input wire logic                     watchdog_kick_op,
   input wire logic                     sleep_op,
   input wire logic                     watchdog_timeout,
   // observed outputs
   input wire logic                     status_hit,
   input wire logic [7:0]               flags,
   input wire logic [8:0]               direct_base,
   input wire logic [8:0]               indirect_base
);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // any reset-cause event taken this cycle
   wire logic any_event = clk_en & (watchdog_kick_op | sleep_op | watchdog_timeout);

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_reset_value: assert property ($fell(rst) |-> flags[7:3] == 5'h03)
      else $error("bank and cause bits wrong after reset");
   a_timeout_clears: assert property (clk_en && watchdog_timeout |=> !flags[4])
      else $error("expiry flag not cleared by timeout");
   a_sleep_flags: assert property (clk_en && sleep_op && !watchdog_timeout && !watchdog_kick_op
      |=> flags[4:3] == 2'b10) else $error("sleep did not set expiry and clear sleep flag");
   a_kick_sets: assert property (clk_en && watchdog_kick_op && !sleep_op && !watchdog_timeout
      |=> flags[4:3] == 2'b11) else $error("kick did not set both cause flags");
   a_cause_hold: assert property (!any_event |=> $stable(flags[4:3]))
      else $error("cause flags changed without an event");
   a_mirror_hit: assert property (status_hit == (exec_valid && exec_addr[6:0] == 7'h03))
      else $error("register hit does not follow mirrored address");
   a_bank_bases: assert property (direct_base == {flags[6:5], 7'h00} && indirect_base == {flags[7], 8'h00})
      else $error("bank base does not match select bits");
   a_clear_file: assert property (exec_valid && clk_en && exec_op == OP_CLEAR_FILE && exec_writes_file
      && status_hit && !any_event |=> flags[7:5] == 3'h0 && flags[2] && flags[1:0] == $past(flags[1:0]))
      else $error("clear of the register gave wrong value");
endmodule

bind status_flags_register status_flags_asserts status_flags_asserts_inst (.clock, .rst, .clk_en, .exec_valid,
   .exec_op, .exec_addr, .exec_writes_file, .watchdog_kick_op, .sleep_op, .watchdog_timeout, .status_hit, .flags,
   .direct_base, .indirect_base);

// *** tb/status_flags_register_bench.sv ***
// testbench: event, bank, clear, bit and alu scenarios for the status flag register
module status_flags_register_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import status_flags_pkg::*;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic       clock = 1'b0;
   logic       rst = 1'b1;
   logic       clk_en = 1'b1;
   logic       exec_valid = 1'b0;
   op_type     exec_op = OP_NONE;
   logic [8:0] exec_addr = 9'h000;
   logic [7:0] exec_dest_value = 8'h00;
   logic [7:0] exec_working = 8'h00;
   logic       exec_writes_file = 1'b0;
   logic       watchdog_kick_op = 1'b0;
   logic       sleep_op = 1'b0;
   logic       watchdog_timeout = 1'b0;
   logic [3:0] sw_addr = 4'h0;
   logic [7:0] sw_wdata = 8'h00;
   logic       sw_write = 1'b0;
   logic       sw_read = 1'b0;
   logic [7:0] exec_result, flags, sw_rdata, ef, v;
   logic [1:0] direct_bank_select;
   logic       indirect_bank_select, status_hit, irq;
   logic [8:0] direct_base, indirect_base;
   int         num_errors = 0;
   int         cmp_count = 0;

   // clock generation
   always #5 clock = ~clock;

   status_flags_register status_flags_register_inst (.clock, .rst, .clk_en, .exec_valid, .exec_op,
      .exec_addr, .exec_dest_value, .exec_working, .exec_writes_file, .watchdog_kick_op, .sleep_op,
      .watchdog_timeout, .exec_result, .status_hit, .flags, .direct_bank_select, .indirect_bank_select,
      .direct_base, .indirect_base, .sw_addr, .sw_wdata, .sw_write, .sw_read, .sw_rdata, .irq);

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic check(input string name, input logic [8:0] exp, input logic [8:0] got);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // one instruction with a file destination
   task automatic run(input op_type op, input logic [8:0] a, input logic [7:0] d, input logic [7:0] w);
      @(posedge clock);
      exec_valid <= 1'b1;
      exec_op <= op;
      exec_addr <= a;
      exec_dest_value <= d;
      exec_working <= w;
      exec_writes_file <= 1'b1;
      @(posedge clock);
      exec_valid <= 1'b0;
      #1;
   endtask
   // one event pulse: 0 timeout, 1 sleep, 2 kick
   task automatic pulse(input int k);
      @(posedge clock);
      watchdog_timeout <= (k == 0);
      sleep_op <= (k == 1);
      watchdog_kick_op <= (k == 2);
      @(posedge clock);
      {watchdog_timeout, sleep_op, watchdog_kick_op} <= 3'h0;
      #1;
   endtask
   task automatic sw_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      sw_write <= 1'b1;
      sw_addr <= a;
      sw_wdata <= d;
      @(posedge clock);
      sw_write <= 1'b0;
      #1;
   endtask
   task automatic sw_rd(input logic [3:0] a, input logic [7:0] exp, input string name);
      @(posedge clock);
      sw_read <= 1'b1;
      sw_addr <= a;
      @(posedge clock);
      sw_read <= 1'b0;
      #1;
      check(name, exp, sw_rdata);
   endtask
   // alu op on an ordinary file; m marks the flags that the op affects
   task automatic alu(input op_type op, input logic [7:0] d, w, r, input logic [2:0] f, m);
      run(op, 9'h020, d, w);
      ef[2:0] = (ef[2:0] & ~m) | (f & m);
      check("result", r, exec_result);
      check("alu_flags", ef, flags);
   endtask

   // ----------------------------------------------------------------
   // hang guard
   // ----------------------------------------------------------------
   initial begin
      repeat (3000) @(posedge clock);
      num_errors++;
      stop_test();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      #1;
      check("cause_bits", 5'h03, flags[7:3]);
      check("irq", 1'b0, irq);
      $display("reset test done");
      sw_wr(REG_IRQ_MASK, 8'h07);
      sw_rd(REG_IRQ_MASK, 8'h07, "irq_mask");
      sw_rd(4'hF, 8'h00, "unmapped");
      pulse(0);
      check("after_timeout", 2'b01, flags[4:3]);
      @(posedge clock);
      #1;
      check("irq_raised", 1'b1, irq);
      sw_rd(REG_IRQ_STATUS, 8'h01, "irq_status");
      pulse(1);
      check("after_sleep", 2'b10, flags[4:3]);
      pulse(2);
      check("after_kick", 2'b11, flags[4:3]);
      sw_rd(REG_IRQ_STATUS, 8'h02, "irq_status");
      sw_wr(REG_IRQ_MASK, 8'h00);
      pulse(0);
      pulse(2);
      check("irq_masked", 1'b0, irq);
      sw_rd(REG_IRQ_STATUS, 8'h01, "irq_status");
      $display("event test done");
      ef = 8'h18;
      for (int b = 0; b < 4; b++) begin
         v = {b[0], b[1:0], 2'b00, b[0], 2'b10};
         run(OP_MOVE_FROM_WORKING, {b[1:0], 7'h03}, ef, v);
         ef = {v[7:5], ef[4:3], v[2:0]};
         check("flags", ef, flags);
         check("banks", {b[0], b[1:0]}, {indirect_bank_select, direct_bank_select});
         check("direct_base", {b[1:0], 7'h00}, direct_base);
         check("indirect_base", {b[0], 8'h00}, indirect_base);
         sw_rd(REG_FLAGS, ef, "flags_port");
      end
      sw_wr(REG_FLAGS, 8'h00);
      check("flags_ro", ef, flags);
      // a frozen clock enable must ignore an event
      @(posedge clock);
      clk_en <= 1'b0;
      pulse(0);
      check("frozen", ef, flags);
      @(posedge clock);
      clk_en <= 1'b1;
      sw_rd(REG_IRQ_STATUS, 8'h00, "frozen_irq");
      $display("bank test done");
      run(OP_CLEAR_FILE, 9'h083, ef, 8'h5A);
      ef = {3'h0, ef[4:3], 1'b1, ef[1:0]};
      check("cleared", ef, flags);
      run(OP_BIT_CLEAR, 9'h103, ef, 8'h10);
      check("bit_clear_cause", ef, flags);
      run(OP_BIT_CLEAR, 9'h183, ef, 8'h04);
      ef[2] = 1'b0;
      check("bit_clear_zero", ef, flags);
      $display("clear and bit test done");
      alu(OP_ADD_FILE, 8'h0F, 8'h01, 8'h10, 3'b010, 3'b111);
      alu(OP_ADD_FILE, 8'hFF, 8'h01, 8'h00, 3'b111, 3'b111);
      alu(OP_SUBTRACT_FILE, 8'h10, 8'h01, 8'h0F, 3'b001, 3'b111);
      alu(OP_SUBTRACT_FILE, 8'h01, 8'h02, 8'hFF, 3'b000, 3'b111);
      alu(OP_SUBTRACT_FILE, 8'h05, 8'h05, 8'h00, 3'b111, 3'b111);
      alu(OP_ROTATE_LEFT, 8'h80, 8'h00, 8'h01, 3'b001, 3'b001);
      alu(OP_ROTATE_RIGHT, 8'h02, 8'h00, 8'h81, 3'b000, 3'b001);
      alu(OP_LOGIC, 8'hF0, 8'h30, 8'h30, 3'b000, 3'b100);
      $display("alu test done");
      // mid-run reset: bank bits cleared, cause bits set, low bits held
      run(OP_MOVE_FROM_WORKING, 9'h003, ef, 8'hE5);
      ef = 8'hFD;
      check("pre_reset", ef, flags);
      @(posedge clock);
      rst <= 1'b1;
      @(posedge clock);
      rst <= 1'b0;
      #1;
      check("mid_reset", 8'h1D, flags);
      check("irq_reset", 1'b0, irq);
      $display("reset hold test done");
      stop_test();
   end
endmodule
